// File: src/usrb_pkg.sv
/*
 * Shared constants for the serial status and receive buffer block:
 * register indices, status field positions, threshold codes, event bits.
 * Assumes a 16-bit register port with a 3-bit word index.
 */
`default_nettype none

package usrb_pkg;

	// ==========================================================
	// Sizes
	localparam int RX_DEPTH = 4;
	localparam int TX_DEPTH = 4;
	localparam int RXW = 11;
	localparam int CW = 3;

	// ==========================================================
	// Register indices
	localparam logic [2:0] REG_STATUS = 3'h0;
	localparam logic [2:0] REG_RXDATA = 3'h1;
	localparam logic [2:0] REG_TXDATA = 3'h2;
	localparam logic [2:0] REG_IRQ_STAT = 3'h3;
	localparam logic [2:0] REG_IRQ_MASK = 3'h4;
	localparam logic [2:0] REG_CONFIG = 3'h5;

	// ==========================================================
	// Status and control field positions
	localparam int B_TXBF = 9;
	localparam int B_TX_SHIFT_EMPTY_FLAG = 8;
	localparam int B_SEL_HI = 7;
	localparam int B_SEL_LO = 6;
	localparam int B_ADDRESS_DETECT_ENABLE = 5;
	localparam int B_RECEIVER_IDLE_FLAG = 4;
	localparam int B_PARITY_ERROR_FLAG = 3;
	localparam int B_FRAMING_ERROR_FLAG = 2;
	localparam int B_OVERRUN_ERROR_FLAG = 1;
	localparam int B_RXDA = 0;
	localparam int B_NINE = 0;

	// ==========================================================
	// Receive threshold codes and fill levels
	localparam logic [1:0] SEL_FULL = 2'h3;
	localparam logic [1:0] SEL_3Q = 2'h2;
	localparam logic [CW-1:0] LVL_FULL = 3'h4;
	localparam logic [CW-1:0] LVL_3Q = 3'h3;

	// ==========================================================
	// Interrupt event bits, queue word layout, reset values
	localparam int EV_RXTH = 0;
	localparam int EV_OVR = 1;
	localparam int EV_FRM = 2;
	localparam int EV_PAR = 3;
	localparam int W_PARITY_ERROR_FLAG = 10;
	localparam int W_FRAMING_ERROR_FLAG = 9;
	localparam logic [15:0] RST_WORD = 16'h0000;

endpackage

`default_nettype wire

// File: src/usrb_rxq_if.sv
/*
 * Link between the status logic and its receive queue.
 * Assumes both ends run on the same clock.
 */
`default_nettype none

interface usrb_rxq_if #(
	parameter int DEPTH = 4,
	parameter int WIDTH = 11
);
	localparam int CW = $clog2(DEPTH + 1);
	logic push;
	logic [WIDTH-1:0] push_word;
	logic pop;
	logic flush;
	logic [CW-1:0] count;
	logic [WIDTH-1:0] head;

	modport owner(output push, output push_word, output pop, output flush,
		input count, input head);
	modport queue(input push, input push_word, input pop, input flush,
		output count, output head);
endinterface

`default_nettype wire

// File: src/usrb_rx_queue.sv
/*
 * Receive character queue, head always in slot 0.
 * Assumes the owner never pushes while full; flush wins over push and pop.
 */
`default_nettype none

module usrb_rx_queue #(
	parameter int DEPTH = usrb_pkg::RX_DEPTH,
	parameter int WIDTH = usrb_pkg::RXW
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Queue port
	usrb_rxq_if.queue q
);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic [DEPTH-1:0][WIDTH-1:0] slot;
	} usrb_q_t;

	usrb_q_t st;
	usrb_q_t next_st;

	// ==========================================================
	// Shift-down queue
	always_comb begin
		next_st = st;
		if (q.flush) begin
			next_st.cnt = '0;
		end else begin
			if (q.pop && st.cnt != '0) begin
				for (int i = 0; i < DEPTH - 1; i++) begin
					next_st.slot[i] = st.slot[i+1];
				end
				next_st.slot[DEPTH-1] = '0;
				next_st.cnt = st.cnt - CW'(1);
			end
			if (q.push && next_st.cnt < CW'(DEPTH)) begin
				next_st.slot[next_st.cnt] = q.push_word;
				next_st.cnt = next_st.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q.count = st.cnt;
	assign q.head = st.slot[0];

endmodule

`default_nettype wire

// File: src/usrb_status.sv
/*
 * Status, receive buffer and interrupt logic of an asynchronous serial port.
 * Assumes a receive engine that offers one-cycle character strobes with
 * error bits, and a transmit shifter that raises busy in the cycle after
 * it accepts a character and holds it until the last bit is out.
 */
// What this block does
// - Shift-empty reads 0 while a character is shifting or queued, 1 only when both are empty.
// - Threshold code 11 fires on the fill to four, 10 on the fill to three, 0x on every fill.
// - The receive buffer holds four characters; three of them count as three-quarters full.
// - With address detect on and 9-bit mode, only characters with ninth bit 1 are taken.
// - Receiver idle reads 1 while no character is arriving and 0 during reception.
// - Parity error reads the flag of the character at the head of the receive queue.
// - Framing error reads the flag of the character at the head of the receive queue.
// - A character arriving with the buffer full sets the overrun flag; software only clears it.
// - Clearing a set overrun flag empties the buffer and resets the receive shift register.
// - Data available reads 1 whenever at least one unread character is in the buffer.
`default_nettype none

module usrb_status (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Receive engine
	input wire logic rx_char_valid,
	input wire logic [8:0] rx_char_data,
	input wire logic rx_parity_bad,
	input wire logic rx_frame_bad,
	input wire logic rx_active,
	output logic rx_shift_clear,
	// Transmit shifter
	output logic tx_char_valid,
	output logic [8:0] tx_char_data,
	input wire logic tx_char_ready,
	input wire logic tx_shift_busy,
	// Interrupt
	output logic irq
);
	localparam int CW = usrb_pkg::CW;
	localparam int TCW = $clog2(usrb_pkg::TX_DEPTH + 1);

	typedef struct packed {
		logic [15:0] rdata;
		logic irq;
		logic [1:0] rx_sel;
		logic addr_en;
		logic nine_bit;
		logic overrun_error_flag;
		logic [3:0] ev;
		logic [3:0] mask;
		logic [TCW-1:0] tx_cnt;
		logic [usrb_pkg::TX_DEPTH-1:0][8:0] tx_slot;
		logic tx_valid;
		logic rx_clear;
	} usrb_state_t;

	usrb_state_t st;
	usrb_state_t next_st;

	usrb_rxq_if #(.DEPTH(usrb_pkg::RX_DEPTH), .WIDTH(usrb_pkg::RXW)) q ();

	usrb_rx_queue #(
		.DEPTH(usrb_pkg::RX_DEPTH),
		.WIDTH(usrb_pkg::RXW)
	) u_rx_queue (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.q(q.queue)
	);

	logic rx_full;
	logic addr_drop;
	logic arrival;
	logic overrun_set;
	logic do_clear;
	logic push;
	logic pop;
	logic [CW-1:0] cnt_after;
	logic thr_hit;
	logic rx_avail_now;
	logic head_parity_error_flag;
	logic head_framing_error_flag;
	logic tx_shift_empty_flag_now;
	logic txbf_now;
	logic tx_take;
	logic tx_put;
	logic wr_status;
	logic [3:0] ev_set;
	logic [3:0] ev_clr;
	logic [15:0] status_word;
	logic [8:0] rx_char_kept;

	// ==========================================================
	// Threshold decode
	function automatic logic usrb_level_hit(input logic [1:0] sel,
		input logic [CW-1:0] cnt);
		unique case (sel)
			usrb_pkg::SEL_FULL: usrb_level_hit = cnt == usrb_pkg::LVL_FULL;
			usrb_pkg::SEL_3Q: usrb_level_hit = cnt == usrb_pkg::LVL_3Q;
			default: usrb_level_hit = 1'b1;
		endcase
	endfunction

	// ==========================================================
	// Receive side decisions
	always_comb begin
		wr_status = reg_wr && reg_addr == usrb_pkg::REG_STATUS;
		rx_full = q.count == usrb_pkg::LVL_FULL;
		addr_drop = st.addr_en && st.nine_bit && !rx_char_data[8];
		arrival = rx_char_valid && !addr_drop;
		overrun_set = arrival && rx_full;
		// Set beats clear: a clear racing a new overrun is dropped
		do_clear = wr_status && !reg_wdata[usrb_pkg::B_OVERRUN_ERROR_FLAG] && st.overrun_error_flag
			&& !overrun_set;
		// Receiver stays parked while overrun is pending
		push = arrival && !rx_full && !st.overrun_error_flag && !do_clear;
		pop = reg_rd && reg_addr == usrb_pkg::REG_RXDATA
			&& q.count != '0 && !do_clear;
		cnt_after = q.count + CW'(push) - CW'(pop);
		thr_hit = push && usrb_level_hit(st.rx_sel, cnt_after);
		rx_avail_now = q.count != '0;
		head_parity_error_flag = rx_avail_now && q.head[usrb_pkg::W_PARITY_ERROR_FLAG];
		head_framing_error_flag = rx_avail_now && q.head[usrb_pkg::W_FRAMING_ERROR_FLAG];
		rx_char_kept = {st.nine_bit && rx_char_data[8], rx_char_data[7:0]};
	end

	assign q.push = push;
	assign q.push_word = {rx_parity_bad, rx_frame_bad, rx_char_kept};
	assign q.pop = pop;
	assign q.flush = do_clear;

	// ==========================================================
	// Transmit side decisions
	always_comb begin
		tx_shift_empty_flag_now = st.tx_cnt == '0 && !tx_shift_busy;
		txbf_now = st.tx_cnt == TCW'(usrb_pkg::TX_DEPTH);
		tx_take = st.tx_valid && tx_char_ready;
		// A write into a full buffer is dropped
		tx_put = reg_wr && reg_addr == usrb_pkg::REG_TXDATA && !txbf_now;
	end

	// ==========================================================
	// Status word and events
	always_comb begin
		status_word = usrb_pkg::RST_WORD;
		status_word[usrb_pkg::B_TXBF] = txbf_now;
		status_word[usrb_pkg::B_TX_SHIFT_EMPTY_FLAG] = tx_shift_empty_flag_now;
		status_word[usrb_pkg::B_SEL_HI:usrb_pkg::B_SEL_LO] = st.rx_sel;
		status_word[usrb_pkg::B_ADDRESS_DETECT_ENABLE] = st.addr_en;
		status_word[usrb_pkg::B_RECEIVER_IDLE_FLAG] = !rx_active;
		status_word[usrb_pkg::B_PARITY_ERROR_FLAG] = head_parity_error_flag;
		status_word[usrb_pkg::B_FRAMING_ERROR_FLAG] = head_framing_error_flag;
		status_word[usrb_pkg::B_OVERRUN_ERROR_FLAG] = st.overrun_error_flag;
		status_word[usrb_pkg::B_RXDA] = rx_avail_now;
		ev_set = 4'h0;
		ev_set[usrb_pkg::EV_RXTH] = thr_hit;
		ev_set[usrb_pkg::EV_OVR] = overrun_set;
		ev_set[usrb_pkg::EV_FRM] = push && rx_frame_bad;
		ev_set[usrb_pkg::EV_PAR] = push && rx_parity_bad;
		ev_clr = 4'h0;
		if (reg_wr && reg_addr == usrb_pkg::REG_IRQ_STAT) begin
			ev_clr = reg_wdata[3:0];
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_st = st;
		// Read data stand for one cycle only
		next_st.rdata = usrb_pkg::RST_WORD;
		if (reg_rd) begin
			unique case (reg_addr)
				usrb_pkg::REG_STATUS: next_st.rdata = status_word;
				usrb_pkg::REG_RXDATA: next_st.rdata = rx_avail_now
					? {7'h00, q.head[8:0]} : usrb_pkg::RST_WORD;
				usrb_pkg::REG_IRQ_STAT: next_st.rdata = {12'h000, st.ev};
				usrb_pkg::REG_IRQ_MASK: next_st.rdata = {12'h000, st.mask};
				usrb_pkg::REG_CONFIG: next_st.rdata = {15'h0000, st.nine_bit};
				default: next_st.rdata = usrb_pkg::RST_WORD;
			endcase
		end
		if (wr_status) begin
			next_st.rx_sel = reg_wdata[usrb_pkg::B_SEL_HI:usrb_pkg::B_SEL_LO];
			next_st.addr_en = reg_wdata[usrb_pkg::B_ADDRESS_DETECT_ENABLE];
		end
		if (reg_wr && reg_addr == usrb_pkg::REG_IRQ_MASK) begin
			next_st.mask = reg_wdata[3:0];
		end
		if (reg_wr && reg_addr == usrb_pkg::REG_CONFIG) begin
			next_st.nine_bit = reg_wdata[usrb_pkg::B_NINE];
		end
		// Software can only clear overrun, never set it
		if (overrun_set) begin
			next_st.overrun_error_flag = 1'b1;
		end else if (do_clear) begin
			next_st.overrun_error_flag = 1'b0;
		end
		next_st.rx_clear = do_clear;
		// Event set wins over a write-one clear in the same cycle
		next_st.ev = (st.ev & ~ev_clr) | ev_set;
		next_st.irq = |(next_st.ev & next_st.mask);
		if (tx_take) begin
			for (int i = 0; i < usrb_pkg::TX_DEPTH - 1; i++) begin
				next_st.tx_slot[i] = st.tx_slot[i+1];
			end
			next_st.tx_slot[usrb_pkg::TX_DEPTH-1] = 9'h000;
			next_st.tx_cnt = st.tx_cnt - TCW'(1);
		end
		if (tx_put) begin
			next_st.tx_slot[next_st.tx_cnt] =
				{st.nine_bit && reg_wdata[8], reg_wdata[7:0]};
			next_st.tx_cnt = next_st.tx_cnt + TCW'(1);
		end
		next_st.tx_valid = next_st.tx_cnt != '0;
	end

	// ==========================================================
	// State register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign irq = st.irq;
	assign tx_char_valid = st.tx_valid;
	assign tx_char_data = st.tx_slot[0];
	assign rx_shift_clear = st.rx_clear;

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	logic rd_status;
	assign rd_status = reg_rd && reg_addr == usrb_pkg::REG_STATUS;

	sequence s_overrun_error_flag_clear;
		do_clear;
	endsequence

	sequence s_rx_flushed;
		q.count == '0 && rx_shift_clear && !st.overrun_error_flag;
	endsequence

	sequence s_fill_to(logic [CW-1:0] lvl);
		push && cnt_after == lvl;
	endsequence

	chk_tx_shift_empty_flag_flag: assert property (
		rd_status |=> reg_rdata[usrb_pkg::B_TX_SHIFT_EMPTY_FLAG] == $past(tx_shift_empty_flag_now))
		else $error("shift-empty flag does not match transmit state");

	chk_thresh_full: assert property (
		st.rx_sel == usrb_pkg::SEL_FULL ##0 s_fill_to(usrb_pkg::LVL_FULL)
		|=> st.ev[usrb_pkg::EV_RXTH])
		else $error("full threshold event missing");

	chk_thresh_3q: assert property (
		st.rx_sel == usrb_pkg::SEL_3Q && push && cnt_after != usrb_pkg::LVL_3Q
		&& !st.ev[usrb_pkg::EV_RXTH] |=> !st.ev[usrb_pkg::EV_RXTH])
		else $error("three-quarter threshold fired at wrong level");

	chk_rx_depth: assert property (
		push && !pop && q.count == CW'(2) |=> q.count == usrb_pkg::LVL_3Q)
		else $error("receive fill count wrong");

	chk_addr_filter: assert property (
		rx_char_valid && st.addr_en && st.nine_bit && !rx_char_data[8]
		|-> !push ##1 q.count == $past(q.count) - CW'($past(pop)))
		else $error("data character taken in address mode");

	chk_idle_flag: assert property (
		rd_status |=> reg_rdata[usrb_pkg::B_RECEIVER_IDLE_FLAG] != $past(rx_active))
		else $error("receiver idle flag wrong");

	chk_parity_error_flag_head: assert property (
		rd_status |=> reg_rdata[usrb_pkg::B_PARITY_ERROR_FLAG] == $past(head_parity_error_flag))
		else $error("parity flag not from head character");

	chk_framing_error_flag_head: assert property (
		rd_status |=> reg_rdata[usrb_pkg::B_FRAMING_ERROR_FLAG] == $past(head_framing_error_flag))
		else $error("framing flag not from head character");

	chk_overrun_set: assert property (
		rx_char_valid && !addr_drop && rx_full |=> st.overrun_error_flag && irq == st.mask[1]
		|| st.overrun_error_flag && st.ev[usrb_pkg::EV_OVR])
		else $error("overrun not flagged");

	chk_overrun_flush: assert property (
		s_overrun_error_flag_clear |=> s_rx_flushed ##1 !rx_shift_clear)
		else $error("overrun clear did not empty the buffer");

	chk_data_avail: assert property (
		rd_status |=> reg_rdata[usrb_pkg::B_RXDA] == $past(rx_avail_now))
		else $error("data available flag wrong");

	chk_txbf_flag: assert property (
		tx_put && !tx_take && st.tx_cnt == TCW'(usrb_pkg::TX_DEPTH - 1)
		|=> (txbf_now and (rd_status |=> reg_rdata[usrb_pkg::B_TXBF])))
		else $error("transmit full flag wrong");

	chk_pop_advance: assert property (
		pop && !push && q.count == CW'(2) |=> q.count == CW'(1))
		else $error("receive read did not advance queue");

	chk_overrun_error_flag_sticky: assert property (
		st.overrun_error_flag && !do_clear |=> st.overrun_error_flag)
		else $error("overrun flag dropped without a clear");

	chk_overrun_error_flag_no_set: assert property (
		!st.overrun_error_flag && !overrun_set |=> !st.overrun_error_flag)
		else $error("overrun flag set without an overrun");

	chk_rx_parked: assert property (
		st.overrun_error_flag |-> !push)
		else $error("character stored while overrun pending");

	chk_tx_shift_empty_flag_busy: assert property (
		tx_shift_busy || st.tx_valid |-> !tx_shift_empty_flag_now)
		else $error("shift-empty set while transmit work remains");

	chk_avail_empty: assert property (
		q.count == '0 |-> !rx_avail_now && !head_parity_error_flag && !head_framing_error_flag)
		else $error("empty buffer reports data or errors");

	chk_txbf_drop: assert property (
		txbf_now && !tx_take |=> st.tx_cnt == TCW'(usrb_pkg::TX_DEPTH))
		else $error("write into full transmit buffer changed it");

endmodule

`default_nettype wire

// File: bench/usrb_line_model.sv
/*
 * Line-side model: remote receive engine and transmit shifter.
 * Assumes the bench calls send_char and may set stall to hold the shifter.
 */
`default_nettype none

module usrb_line_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Receive engine
	output logic rx_char_valid,
	output logic [8:0] rx_char_data,
	output logic rx_parity_bad,
	output logic rx_frame_bad,
	output logic rx_active,
	// Transmit shifter
	input wire logic tx_char_valid,
	input wire logic [8:0] tx_char_data,
	output logic tx_char_ready,
	output logic tx_shift_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Transmit shifter, slow on purpose
	logic stall = 1'b0;
	logic [3:0] busy_cnt;
	logic [8:0] got[$];
	assign tx_char_ready = (busy_cnt == 4'h0) && !stall;
	assign tx_shift_busy = busy_cnt != 4'h0;
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			busy_cnt <= 4'h0;
		end else if (tx_char_valid && tx_char_ready) begin
			busy_cnt <= 4'h9;
			got.push_back(tx_char_data);
		end else if (busy_cnt != 4'h0) begin
			busy_cnt <= busy_cnt - 4'h1;
		end
	end
	// ==========================================
	// Receive engine
	initial begin
		rx_char_valid = 1'b0;
		rx_char_data = 9'h000;
		rx_parity_bad = 1'b0;
		rx_frame_bad = 1'b0;
		rx_active = 1'b0;
	end
	// Lines show the inverse afterwards so stale data never looks valid
	task automatic send_char(input logic [8:0] d, input logic p, input logic f);
		@(posedge sys_clk);
		rx_active <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rx_char_valid <= 1'b1;
		rx_char_data <= d;
		rx_parity_bad <= p;
		rx_frame_bad <= f;
		@(posedge sys_clk);
		rx_char_valid <= 1'b0;
		rx_active <= 1'b0;
		rx_char_data <= ~d;
		rx_parity_bad <= ~p;
		rx_frame_bad <= ~f;
	endtask
endmodule

`default_nettype wire

// File: bench/usrb_status_tb_top.sv
/*
 * Self-checking bench for the serial status and receive buffer block.
 * Assumes the line model stands in for the receive engine and shifter.
 */
`default_nettype none

`define CHK(nm, e, g) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("[FAIL] %s expected %h seen %h", nm, e, g); \
	end \
end

module usrb_status_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Signals
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic rx_char_valid, rx_parity_bad, rx_frame_bad, rx_active, rx_shift_clear;
	logic [8:0] rx_char_data, tx_char_data;
	logic tx_char_valid, tx_char_ready, tx_shift_busy, irq;
	int n_fail = 0;
	int samples_checked = 0;
	int n_clr = 0;
	int cyc = 0;

	always #5 sys_clk = ~sys_clk;

	usrb_status u_usrb_status (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
		.rx_parity_bad(rx_parity_bad), .rx_frame_bad(rx_frame_bad), .rx_active(rx_active),
		.rx_shift_clear(rx_shift_clear), .tx_char_valid(tx_char_valid),
		.tx_char_data(tx_char_data), .tx_char_ready(tx_char_ready),
		.tx_shift_busy(tx_shift_busy), .irq(irq));
	usrb_line_model u_usrb_line_model (.sys_clk(sys_clk), .rst_n(rst_n),
		.rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
		.rx_parity_bad(rx_parity_bad), .rx_frame_bad(rx_frame_bad), .rx_active(rx_active),
		.tx_char_valid(tx_char_valid), .tx_char_data(tx_char_data),
		.tx_char_ready(tx_char_ready), .tx_shift_busy(tx_shift_busy));

	// Timeout well above the few hundred cycles the run needs
	always @(posedge sys_clk) begin
		cyc++;
		if (rx_shift_clear === 1'b1) begin
			n_clr++;
		end
		if (cyc == 20000) begin
			n_fail++;
			results();
		end
	end
	// ==========================================
	// Register port
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK("reg_rdata", e, reg_rdata)
	endtask
	task automatic snd(input logic [8:0] d, input logic p, input logic f);
		u_usrb_line_model.send_char(d, p, f);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		rd(usrb_pkg::REG_STATUS, 16'h0110);
		rd(3'h7, 16'h0000);
		`CHK("irq", 1'b0, irq)
	endtask
	task automatic t_fill();
		wr(usrb_pkg::REG_IRQ_MASK, 16'h0001);
		wr(usrb_pkg::REG_STATUS, 16'h0082);
		snd(9'h011, 1'b1, 1'b0);
		snd(9'h022, 1'b0, 1'b1);
		rd(usrb_pkg::REG_IRQ_STAT, 16'h000c);
		snd(9'h033, 1'b0, 1'b0);
		rd(usrb_pkg::REG_IRQ_STAT, 16'h000d);
		`CHK("irq", 1'b1, irq)
		rd(usrb_pkg::REG_STATUS, 16'h0199);
		wr(usrb_pkg::REG_IRQ_MASK, 16'h0000);
		@(posedge sys_clk);
		#1;
		`CHK("irq", 1'b0, irq)
		wr(usrb_pkg::REG_IRQ_MASK, 16'h0001);
		wr(usrb_pkg::REG_IRQ_STAT, 16'h0001);
		@(posedge sys_clk);
		#1;
		`CHK("irq", 1'b0, irq)
		snd(9'h044, 1'b0, 1'b0);
		rd(usrb_pkg::REG_IRQ_STAT, 16'h000c);
		snd(9'h055, 1'b0, 1'b0);
		rd(usrb_pkg::REG_STATUS, 16'h019b);
		rd(usrb_pkg::REG_RXDATA, 16'h0011);
		rd(usrb_pkg::REG_STATUS, 16'h0197);
		wr(usrb_pkg::REG_STATUS, 16'h0080);
		rd(usrb_pkg::REG_STATUS, 16'h0190);
		`CHK("rx_shift_clear", 1, n_clr)
		rd(usrb_pkg::REG_RXDATA, 16'h0000);
		wr(usrb_pkg::REG_IRQ_STAT, 16'h000f);
	endtask
	task automatic t_sel();
		logic [1:0] codes[3] = '{2'h0, 2'h1, 2'h3};
		foreach (codes[c]) begin
			wr(usrb_pkg::REG_STATUS, {8'h00, codes[c], 6'h02});
			for (int i = 1; i <= 4; i++) begin
				snd(9'(i), 1'b0, 1'b0);
				rd(usrb_pkg::REG_IRQ_STAT, 16'((codes[c] != 2'h3) || (i == 4)));
				wr(usrb_pkg::REG_IRQ_STAT, 16'h0001);
			end
			for (int i = 1; i <= 4; i++) begin
				rd(usrb_pkg::REG_RXDATA, 16'(i));
			end
		end
	endtask
	task automatic t_addr();
		wr(usrb_pkg::REG_CONFIG, 16'h0001);
		wr(usrb_pkg::REG_STATUS, 16'h0022);
		snd(9'h055, 1'b0, 1'b0);
		snd(9'h1aa, 1'b0, 1'b0);
		rd(usrb_pkg::REG_STATUS, 16'h0131);
		rd(usrb_pkg::REG_RXDATA, 16'h01aa);
		wr(usrb_pkg::REG_CONFIG, 16'h0000);
		snd(9'h055, 1'b0, 1'b0);
		rd(usrb_pkg::REG_RXDATA, 16'h0055);
	endtask
	task automatic t_tx();
		wr(usrb_pkg::REG_STATUS, 16'h0002);
		u_usrb_line_model.stall <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			wr(usrb_pkg::REG_TXDATA, 16'(8'ha1 + i));
		end
		rd(usrb_pkg::REG_STATUS, 16'h0210);
		u_usrb_line_model.stall <= 1'b0;
		for (int k = 0; k < 200 && u_usrb_line_model.got.size() < 4; k++) begin
			@(posedge sys_clk);
		end
		rd(usrb_pkg::REG_STATUS, 16'h0010);
		for (int k = 0; k < 50 && tx_shift_busy; k++) begin
			@(posedge sys_clk);
		end
		rd(usrb_pkg::REG_STATUS, 16'h0110);
		`CHK("tx count", 4, u_usrb_line_model.got.size())
		foreach (u_usrb_line_model.got[i]) begin
			`CHK("tx char", 9'(8'ha1 + i), u_usrb_line_model.got[i])
		end
	endtask
	task automatic t_idle();
		fork
			snd(9'h0c3, 1'b0, 1'b0);
			begin
				repeat (2) @(posedge sys_clk);
				rd(usrb_pkg::REG_STATUS, 16'h0100);
			end
		join
		rd(usrb_pkg::REG_RXDATA, 16'h00c3);
	endtask
	// ==========================================
	// Verdict and main sequence
	task automatic results();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_fill();
		t_sel();
		t_addr();
		t_tx();
		t_idle();
		results();
	end
endmodule

`default_nettype wire
